/* File: design/jtds_top.sv */
`timescale 1ns/1ps
module jtds_top (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic chipResetLow,
  input wire logic pllLocked,
  output logic bootStart,
  input wire logic testClk,
  input wire logic testResetLow,
  input wire jtds_pkg::jtds_scan_in_type scanIn,
  output jtds_pkg::jtds_scan_out_type scanOut,
  input wire logic [jtds_pkg::BSR_W-1:0] pinSample,
  output logic [jtds_pkg::BSR_W-1:0] pinDrive,
  output logic extestActive,
  input wire logic [jtds_pkg::UC_USER_W-1:0] securityUserId,
  output logic chipTapSel,
  output logic chipTms,
  output logic chipTdi,
  input wire logic chipTdo,
  input wire logic syncOutMode,
  input wire logic syncInMode,
  input wire logic breakpointHit,
  input wire logic syncPinIn,
  output logic syncPinOut,
  output logic syncPinOe,
  output logic debugRequest
);
  import jtds_pkg::*;

  function automatic logic tapMove(input jtds_tap_type s, input logic m);
    return (s == UPD_DR) || (s == UPD_IR) ? 1'b0 : m;
  endfunction : tapMove

  // Next TAP state for tms high and tms low
  function automatic jtds_tap_type tapNext(input jtds_tap_type s, input logic m);
    jtds_tap_type hi;
    jtds_tap_type lo;
    hi = s;
    lo = s;
    unique case (s)
      TL_RESET: begin
        hi = TL_RESET;
        lo = RUN_IDLE;
      end
      RUN_IDLE: begin
        hi = SEL_DR;
        lo = RUN_IDLE;
      end
      SEL_DR: begin
        hi = SEL_IR;
        lo = CAP_DR;
      end
      CAP_DR: begin
        hi = EXIT1_DR;
        lo = SHIFT_DR;
      end
      SHIFT_DR: begin
        hi = EXIT1_DR;
        lo = SHIFT_DR;
      end
      EXIT1_DR: begin
        hi = UPD_DR;
        lo = PAUSE_DR;
      end
      PAUSE_DR: begin
        hi = EXIT2_DR;
        lo = PAUSE_DR;
      end
      EXIT2_DR: begin
        hi = UPD_DR;
        lo = SHIFT_DR;
      end
      UPD_DR: begin
        hi = SEL_DR;
        lo = RUN_IDLE;
      end
      SEL_IR: begin
        hi = TL_RESET;
        lo = CAP_IR;
      end
      CAP_IR: begin
        hi = EXIT1_IR;
        lo = SHIFT_IR;
      end
      SHIFT_IR: begin
        hi = EXIT1_IR;
        lo = SHIFT_IR;
      end
      EXIT1_IR: begin
        hi = UPD_IR;
        lo = PAUSE_IR;
      end
      PAUSE_IR: begin
        hi = EXIT2_IR;
        lo = PAUSE_IR;
      end
      EXIT2_IR: begin
        hi = UPD_IR;
        lo = SHIFT_IR;
      end
      UPD_IR: begin
        hi = SEL_DR;
        lo = RUN_IDLE;
      end
    endcase
    return m ? hi : lo;
  endfunction : tapNext

  function automatic logic isBoundary(input logic [jtds_pkg::IR_W-1:0] ir);
    return (ir == IR_EXTEST) || (ir == IR_SAMPLE);
  endfunction : isBoundary

  // TAP domain on test clock
  jtds_tap_type tap_r, tap_nxt;
  logic [IR_W-1:0] irShift_r, irShift_nxt, ir_r, ir_nxt;
  logic [DR_W-1:0] dr_r, dr_nxt;
  logic [BSR_W-1:0] bsrUpd_r, bsrUpd_nxt;
  logic tdo_r, tdo_nxt, tdoEn_r, tdoEn_nxt;
  logic [UC_USER_W-1:0] uid_r, uid_nxt;
  logic [DR_W-1:0] idWord, ucWord;

  assign idWord = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};
  assign ucWord = {uid_r, {UC_UNUSED_W{1'b0}}, UC_SILICON_REV};

  // Enable and user ID resynchronised to the test clock
  logic [1:0] enSync_r, enSync_nxt;
  logic [UC_USER_W-1:0] uidMeta_r, uidMeta_nxt;
  logic tapRun;

  always_comb begin
    enSync_nxt = {enSync_r[0], clkEn};
    uidMeta_nxt = securityUserId;
  end

  always_ff @(posedge testClk or negedge testResetLow) begin
    if (!testResetLow) begin
      enSync_r <= '0;
      uidMeta_r <= '0;
    end else begin
      enSync_r <= enSync_nxt;
      uidMeta_r <= uidMeta_nxt;
    end
  end

  assign tapRun = enSync_r[1];

  always_comb begin
    tap_nxt = tapNext(tap_r, scanIn.tms);
  end

  always_comb begin
    irShift_nxt = irShift_r;
    ir_nxt = ir_r;
    dr_nxt = dr_r;
    bsrUpd_nxt = bsrUpd_r;
    uid_nxt = uidMeta_r;
    if (tap_r == TL_RESET) begin
      ir_nxt = IR_DEVICE_IDENTIFICATION;
    end
    unique case (tap_r)
      CAP_IR: irShift_nxt = IR_CAPTURE;
      SHIFT_IR: irShift_nxt = {scanIn.tdi, irShift_r[IR_W-1:1]};
      UPD_IR: ir_nxt = irShift_r;
      CAP_DR: begin
        unique case (ir_r)
          IR_DEVICE_IDENTIFICATION: dr_nxt = idWord;
          IR_USERCODE: dr_nxt = ucWord;
          IR_EXTEST, IR_SAMPLE: dr_nxt = {{(DR_W-BSR_W){1'b0}}, pinSample};
          default: dr_nxt = '0;
        endcase
      end
      SHIFT_DR: begin
        if (isBoundary(ir_r)) begin
          dr_nxt = {{(DR_W-BSR_W){1'b0}}, scanIn.tdi, dr_r[BSR_W-1:1]};
        end else if (ir_r == IR_DEVICE_IDENTIFICATION || ir_r == IR_USERCODE) begin
          dr_nxt = {scanIn.tdi, dr_r[DR_W-1:1]};
        end else begin
          dr_nxt = {{(DR_W-1){1'b0}}, scanIn.tdi};
        end
      end
      UPD_DR: begin
        if (isBoundary(ir_r)) begin
          bsrUpd_nxt = dr_r[BSR_W-1:0];
        end
      end
      default: ;
    endcase
  end

  // Output stage on falling test clock
  always_comb begin
    tdoEn_nxt = (tap_r == SHIFT_DR) || (tap_r == SHIFT_IR);
    if (tap_r == SHIFT_IR) begin
      tdo_nxt = irShift_r[0];
    end else if (ir_r == IR_CHIPTAP) begin
      tdo_nxt = chipTdo;
    end else begin
      tdo_nxt = dr_r[0];
    end
  end

  always_ff @(posedge testClk or negedge testResetLow) begin
    if (!testResetLow) begin
      tap_r <= TL_RESET;
      irShift_r <= '0;
      ir_r <= IR_DEVICE_IDENTIFICATION;
      dr_r <= '0;
      bsrUpd_r <= '0;
      uid_r <= '0;
    end else if (tapRun) begin
      tap_r <= tap_nxt;
      irShift_r <= irShift_nxt;
      ir_r <= ir_nxt;
      dr_r <= dr_nxt;
      bsrUpd_r <= bsrUpd_nxt;
      uid_r <= uid_nxt;
    end
  end

  always_ff @(negedge testClk or negedge testResetLow) begin
    if (!testResetLow) begin
      tdo_r <= 1'b0;
      tdoEn_r <= 1'b0;
    end else if (tapRun) begin
      tdo_r <= tdo_nxt;
      tdoEn_r <= tdoEn_nxt;
    end
  end

  assign scanOut = '{tdo: tdo_r, tdoEn: tdoEn_r};
  assign pinDrive = bsrUpd_r;
  assign extestActive = (ir_r == IR_EXTEST);
  assign chipTapSel = (ir_r == IR_CHIPTAP);
  assign chipTms = chipTapSel ? tapMove(tap_r, scanIn.tms) : 1'b1;
  assign chipTdi = scanIn.tdi;

  // System domain
  logic rstMeta_r, rstSync_r;
  logic [1:0] lockSync_r, lockSync_nxt;
  logic [1:0] bpSync_r, bpSync_nxt, pinSync_r, pinSync_nxt;
  logic boot_r, boot_nxt, oe_r, oe_nxt, dbg_r, dbg_nxt;

  always_ff @(posedge clk or negedge chipResetLow) begin
    if (!chipResetLow) begin
      rstMeta_r <= 1'b1;
      rstSync_r <= 1'b1;
    end else begin
      rstMeta_r <= 1'b0;
      rstSync_r <= rstMeta_r;
    end
  end

  always_comb begin
    lockSync_nxt = {lockSync_r[0], pllLocked};
    bpSync_nxt = {bpSync_r[0], breakpointHit};
    pinSync_nxt = {pinSync_r[0], syncPinIn};
    boot_nxt = boot_r | lockSync_r[1];
    oe_nxt = syncOutMode & (oe_r | bpSync_r[1]);
    dbg_nxt = syncInMode & ~pinSync_r[1];
  end

  always_ff @(posedge clk or negedge chipResetLow) begin
    if (!chipResetLow) begin
      lockSync_r <= '0;
      bpSync_r <= '0;
      pinSync_r <= 2'h3;
      boot_r <= 1'b0;
      oe_r <= 1'b0;
      dbg_r <= 1'b0;
    end else if (sys_rst || rstSync_r) begin
      lockSync_r <= '0;
      bpSync_r <= '0;
      pinSync_r <= 2'h3;
      boot_r <= 1'b0;
      oe_r <= 1'b0;
      dbg_r <= 1'b0;
    end else if (clkEn) begin
      lockSync_r <= lockSync_nxt;
      bpSync_r <= bpSync_nxt;
      pinSync_r <= pinSync_nxt;
      boot_r <= boot_nxt;
      oe_r <= oe_nxt;
      dbg_r <= dbg_nxt;
    end
  end

  assign bootStart = boot_r;
  assign syncPinOut = 1'b0;
  assign syncPinOe = oe_r;
  assign debugRequest = dbg_r;
endmodule : jtds_top

/* File: design/jtds_pkg.sv */
package jtds_pkg;
  localparam int IR_W = 4;
  localparam int DR_W = 32;
  localparam logic [IR_W-1:0] IR_EXTEST = 4'h0;
  localparam logic [IR_W-1:0] IR_SAMPLE = 4'h1;
  localparam logic [IR_W-1:0] IR_DEVICE_IDENTIFICATION = 4'h2;
  localparam logic [IR_W-1:0] IR_USERCODE = 4'h3;
  localparam logic [IR_W-1:0] IR_CHIPTAP = 4'h4;
  localparam logic [IR_W-1:0] IR_BYPASS = 4'hf;
  localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
  // Arbitrary neutral identity values
  localparam logic [3:0] ID_VERSION = 4'h1;
  localparam logic [15:0] ID_PART = 16'h00a5;
  localparam logic [10:0] ID_MAKER = 11'h05a;
  localparam int UC_USER_W = 10;
  localparam int UC_UNUSED_W = 6;
  localparam int UC_REV_W = 16;
  localparam logic [UC_REV_W-1:0] UC_SILICON_REV = 16'h0001;
  localparam int BSR_W = 8;
  typedef enum logic [3:0] {
    TL_RESET, RUN_IDLE, SEL_DR, CAP_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR, UPD_DR,
    SEL_IR, CAP_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR, UPD_IR
  } jtds_tap_type;
  typedef struct packed {
    logic tms;
    logic tdi;
  } jtds_scan_in_type;
  typedef struct packed {
    logic tdo;
    logic tdoEn;
  } jtds_scan_out_type;
endpackage : jtds_pkg

/* File: tb/jtds_sva.sv */
`timescale 1ns/1ps
module jtds_sva (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic chipResetLow,
  input wire logic pllLocked,
  input wire logic bootStart,
  input wire logic testClk,
  input wire logic testResetLow,
  input wire jtds_pkg::jtds_scan_out_type scanOut,
  input wire logic extestActive,
  input wire logic chipTapSel,
  input wire logic chipTms,
  input wire logic breakpointHit,
  input wire logic syncOutMode,
  input wire logic syncPinIn,
  input wire logic syncPinOut,
  input wire logic syncPinOe,
  input wire logic debugRequest
);
  import jtds_pkg::*;
  a_tap_held_reset: assert property (@(posedge testClk) disable iff (sys_rst)
    !testResetLow |-> !scanOut.tdoEn) else $error("tdo enabled in reset");
  a_sel_exclusive: assert property (@(posedge testClk) disable iff (!testResetLow)
    !(extestActive && chipTapSel)) else $error("two selects");
  a_chip_tms_idle: assert property (@(posedge testClk) disable iff (!testResetLow)
    !chipTapSel |-> chipTms) else $error("chip tms not idle");
  a_boot_reset_low: assert property (@(posedge clk) disable iff (sys_rst)
    !chipResetLow |-> !bootStart) else $error("boot in reset");
  a_boot_needs_lock: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(bootStart) |-> $past(pllLocked, 3)) else $error("boot without lock");
  a_sync_drive_low: assert property (@(posedge clk) disable iff (sys_rst)
    syncPinOe |-> !syncPinOut) else $error("sync pin driven high");
  a_sync_after_bp: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(syncPinOe) |-> $past(breakpointHit, 3) && syncOutMode) else $error("early drive");
  a_debug_on_low: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(debugRequest) |-> $past(syncPinIn, 3) == 1'b0) else $error("debug without low");
endmodule : jtds_sva
bind jtds_top jtds_sva i_jtds_sva (.clk(clk), .sys_rst(sys_rst), .chipResetLow(chipResetLow),
  .pllLocked(pllLocked), .bootStart(bootStart), .testClk(testClk), .testResetLow(testResetLow),
  .scanOut(scanOut), .extestActive(extestActive), .chipTapSel(chipTapSel), .chipTms(chipTms),
  .breakpointHit(breakpointHit), .syncOutMode(syncOutMode), .syncPinIn(syncPinIn),
  .syncPinOut(syncPinOut), .syncPinOe(syncPinOe), .debugRequest(debugRequest));

/* File: tb/jtds_host.sv */
`timescale 1ns/1ps
module jtds_host (
  output logic testClk,
  output jtds_pkg::jtds_scan_in_type scanIn,
  input wire jtds_pkg::jtds_scan_out_type scanOut
);
  import jtds_pkg::*;
  initial begin
    testClk = 1'b0;
    scanIn = '0;
  end
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    scanIn = '{tms: tms, tdi: tdi};
    #24 testClk = 1'b1;
    tdo = scanOut.tdo;
    #24 testClk = 1'b0;
  endtask : step
  task automatic idle();
    logic b;
    repeat (5) step(1'b1, ~scanIn.tdi, b);
    step(1'b0, ~scanIn.tdi, b);
  endtask : idle
  task automatic shift(input logic isIr, input int n, input logic [31:0] din,
                       output logic [31:0] dout);
    logic b;
    dout = '0;
    step(1'b1, ~scanIn.tdi, b);
    if (isIr) step(1'b1, ~scanIn.tdi, b);
    repeat (2) step(1'b0, ~scanIn.tdi, b);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], b);
      dout[i] = b;
    end
    step(1'b1, ~scanIn.tdi, b);
    step(1'b0, ~scanIn.tdi, b);
  endtask : shift
endmodule : jtds_host

/* File: tb/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import jtds_pkg::*;
  logic clk = 1'b0, sys_rst = 1'b1, chipResetLow = 1'b0, pllLocked = 1'b0, testResetLow = 1'b0;
  logic breakpointHit = 1'b0, syncOutMode = 1'b0, syncInMode = 1'b0, pinLow = 1'b0;
  logic bootStart, testClk, extestActive, chipTapSel, chipTms, chipTdi;
  logic syncPinOut, syncPinOe, debugRequest;
  logic [7:0] pinDrive;
  jtds_scan_in_type scanIn;
  jtds_scan_out_type scanOut;
  logic [31:0] got, rowExp[6];
  logic [3:0] rowIr[6];
  int failCount = 0, samplesChecked = 0, cycles = 0;
  localparam logic [31:0] DIN = 32'hc3a5_0f96;
  wire logic chipTdo = ~chipTdi;
  wire logic syncPinIn = !(syncPinOe || pinLow);
  always #2.5 clk = ~clk;
  jtds_host i_jtds_host (.testClk(testClk), .scanIn(scanIn), .scanOut(scanOut));
  jtds_top i_jtds_top (.clk(clk), .sys_rst(sys_rst), .clkEn(1'b1), .chipResetLow(chipResetLow),
    .pllLocked(pllLocked), .bootStart(bootStart), .testClk(testClk), .testResetLow(testResetLow),
    .scanIn(scanIn), .scanOut(scanOut), .pinSample(8'h5c), .pinDrive(pinDrive),
    .extestActive(extestActive), .securityUserId(10'h2b3), .chipTapSel(chipTapSel),
    .chipTms(chipTms), .chipTdi(chipTdi), .chipTdo(chipTdo), .syncOutMode(syncOutMode),
    .syncInMode(syncInMode), .breakpointHit(breakpointHit), .syncPinIn(syncPinIn),
    .syncPinOut(syncPinOut), .syncPinOe(syncPinOe), .debugRequest(debugRequest));
  task automatic chk(input logic ok, input string msg);
    samplesChecked++;
    if (ok !== 1'b1) begin
      $display("CHECK FAILED at %0t: %s", $time, msg);
      failCount++;
    end
  endtask : chk
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", samplesChecked, failCount);
    if (failCount == 0 && samplesChecked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      failCount++;
      conclude();
    end
  end
  initial begin
    rowIr = '{IR_DEVICE_IDENTIFICATION, IR_USERCODE, IR_BYPASS, 4'he, IR_SAMPLE, IR_EXTEST};
    rowExp = '{{ID_VERSION, ID_PART, ID_MAKER, 1'b1}, {10'h2b3, 6'h00, UC_SILICON_REV},
      {DIN[30:0], 1'b0}, {DIN[30:0], 1'b0}, {DIN[23:0], 8'h5c}, {DIN[23:0], 8'h5c}};
    repeat (10) @(negedge clk);
    sys_rst = 1'b0;
    chipResetLow = 1'b1;
    repeat (8) @(negedge clk);
    chk(bootStart === 1'b0, "boot before lock");
    pllLocked = 1'b1;
    repeat (6) @(negedge clk);
    chk(bootStart === 1'b1, "no boot after lock");
    #1 chipResetLow = 1'b0;
    #1 chk(bootStart === 1'b0, "reset not async");
    @(negedge clk) chipResetLow = 1'b1;
    repeat (2) @(negedge clk);
    chk(bootStart === 1'b0, "boot too early after release");
    repeat (6) @(negedge clk);
    chk(bootStart === 1'b1, "no boot after second release");
    $display("test boot done");
    i_jtds_host.idle();
    testResetLow = 1'b1;
    i_jtds_host.idle();
    i_jtds_host.shift(1'b0, 32, DIN, got);
    chk(got === rowExp[0], "reset instruction");
    for (int i = 0; i < 6; i++) begin
      i_jtds_host.shift(1'b1, 4, {28'h0, rowIr[i]}, got);
      chk(got[3:0] === IR_CAPTURE, "ir capture");
      i_jtds_host.shift(1'b0, 32, DIN, got);
      chk(got === rowExp[i], "data word");
    end
    chk(extestActive === 1'b1 && pinDrive === DIN[31:24], "extest");
    i_jtds_host.shift(1'b1, 4, {28'h0, IR_CHIPTAP}, got);
    chk(chipTapSel === 1'b1, "chip tap");
    $display("test scan done");
    @(negedge clk) syncOutMode = 1'b1;
    repeat (5) @(negedge clk);
    chk(syncPinOe === 1'b0, "pin not floating");
    breakpointHit = 1'b1;
    repeat (5) @(negedge clk);
    chk(syncPinOe === 1'b1, "pin not driven");
    syncOutMode = 1'b0;
    breakpointHit = 1'b0;
    syncInMode = 1'b1;
    repeat (5) @(negedge clk);
    chk(debugRequest === 1'b0, "debug while pin high");
    pinLow = 1'b1;
    repeat (5) @(negedge clk);
    chk(debugRequest === 1'b1, "no debug request");
    $display("test sync done");
    conclude();
  end
endmodule : testbench
